// >>> gxp_defs.svh
// Constants for the serial port expander: register offsets, resets and timing
`ifndef GXP_DEFS_SVH
`define GXP_DEFS_SVH

// ----------------------------------------
// Register offsets (command byte values)
// ----------------------------------------
`define GXP_REG_IN_LO    8'h00
`define GXP_REG_IN_HI    8'h01
`define GXP_REG_PH0_LO   8'h02
`define GXP_REG_PH0_HI   8'h03
`define GXP_REG_PH1_LO   8'h04
`define GXP_REG_PH1_HI   8'h05
`define GXP_REG_DIR_LO   8'h06
`define GXP_REG_DIR_HI   8'h07
`define GXP_REG_MASTER   8'h08
`define GXP_REG_CFG      8'h09
`define GXP_REG_PWM_LO   8'h0A
`define GXP_REG_PWM_HI   8'h0B
`define GXP_REG_INT_BASE 8'h0C
`define GXP_REG_LAST     8'h14

// ----------------------------------------
// Configuration register fields
// ----------------------------------------
`define GXP_CFG_BLINK_EN   0
`define GXP_CFG_BLINK_FLIP 1
`define GXP_CFG_GLOBAL     2
`define GXP_CFG_IRQ_MODE   3
`define GXP_CFG_O16_PH0    4
`define GXP_CFG_O16_PH1    5
`define GXP_CFG_O16_PWM    6

// ----------------------------------------
// Reset values
// ----------------------------------------
`define GXP_RST_PORT16 16'hFFFF
`define GXP_RST_CFG    8'h30

// ----------------------------------------
// Timing
// ----------------------------------------
`define GXP_REF_CLK_HZ   10000000
`define GXP_PWM_OSC_HZ   32000
`define GXP_PWM_TICK_CYC (`GXP_REF_CLK_HZ / `GXP_PWM_OSC_HZ)
`define GXP_PWM_STEPS    8'hF0

`endif

// >>> gxp_pkg.sv
// Types shared by the serial port expander
package gxp_pkg;

  // ----------------------------------------
  // Serial slave states
  // ----------------------------------------
  typedef enum logic [2:0] {
    GXP_IDLE,
    GXP_ADDR,
    GXP_ADDR_ACK,
    GXP_WR,
    GXP_WR_ACK,
    GXP_RD,
    GXP_RD_ACK
  } gxp_mode_t;

  // ----------------------------------------
  // Open-drain pin carriers
  // ----------------------------------------
  typedef struct packed {
    logic scl;
    logic sda;
  } gxp_bus_in_t;

  typedef struct packed {
    logic sda_o;
    logic sda_oe;
  } gxp_bus_out_t;

  // ----------------------------------------
  // Whole state of the expander
  // ----------------------------------------
  typedef struct packed {
    logic [1:0]       scl_s;
    logic [1:0]       sda_s;
    logic             scl_d;
    logic             sda_d;
    logic [1:0][15:0] pin_s;
    logic [1:0][2:0]  ad_s;
    logic [2:0]       dif_scl;
    logic [2:0]       dif_sda;
    logic [2:0]       seen1;
    logic [2:0]       seen0;
    gxp_mode_t        mode;
    logic [3:0]       bit_cnt;
    logic [7:0]       shreg;
    logic             cmd_phase;
    logic             mack;
    logic [7:0]       ptr;
    logic             sda_oe;
    logic [15:0]      ph0;
    logic [15:0]      ph1;
    logic [15:0]      dir;
    logic [7:0]       cfg;
    logic [3:0]       master;
    logic [15:0]      pwm_en;
    logic [16:0][3:0] ind;
    logic [15:0]      snap;
    logic             irq;
    logic [8:0]       pwm_div;
    logic [7:0]       pwm_cnt;
    logic [15:0]      drv;
    logic             drv16;
  } gxp_st_t;

endpackage : gxp_pkg

// >>> gxp_expander.sv
// Serial-controlled 16-port open-drain expander with blink, PWM and change interrupt
//
// Operation
// - Sixteen two-way port pins plus one output-only pin, interrupt or output.
// - Every port comes out of reset configured as an input.
// - Input registers show live pin levels whether input or output.
// - Reading an input register snapshots its eight pins for comparison.
// - Input differing from snapshot pulls interrupt low when pin in interrupt mode.
// - Interrupt releases when input returns or its input register is read.
// - Extra pin as output takes static, blink and intensity controls.
// - Blink disabled: all ports driven from phase-zero registers.
// - Blink enabled: flip flag selects phase-zero or phase-one registers.
// - PWM timing comes from a nominal 32 kHz internal tick.
// - PWM enabled per output; others are glitch-free static outputs.
// - No output using PWM: outputs static and tick generator stopped.
// - Four-bit master intensity sets window from 1/15 to 15/15.
// - Four-bit per-output intensity scales duty inside window, 1/16 to 15/16.
// - Optional single global intensity replaces individual ones, 240 steps.
// - Standby whenever serial interface idle and no output uses PWM.
// - START and STOP framed by master are detected by the device.
// - One bit per clock pulse; data stable while clock high.
// - Ninth clock acknowledges; receiver holds data low.
// - Address phase: 7-bit slave address then direction bit, low writes.
// - Address decoded from three select pins tied four ways, 64 addresses.
// - First written byte is the command; STOP right after only stores it.
// - Further write bytes go to successive registers as pointer advances.
// - Reads start at stored pointer, set beforehand by a write.
`timescale 1ns/1ns
`include "gxp_defs.svh"

module gxp_expander
  import gxp_pkg::*;
#(
  parameter int PWM_TICK_CYC = `GXP_PWM_TICK_CYC  // Reference cycles per PWM tick
) (
  input  wire logic         ref_clk,            // 10 MHz clock
  input  wire logic         resetn,             // Asynchronous reset, active low
  input  wire logic         ce,                 // Clock enable, freezes all state
  input  wire gxp_bus_in_t  bus_in,             // Serial clock and data levels
  output gxp_bus_out_t      bus_out,            // Data line drive
  input  wire logic [15:0]  port_pins_i,        // Port pin levels
  output logic [15:0]       port_pins_o,        // Port pin drive value
  output logic [15:0]       port_pins_oe,       // Port pin pull-down enable
  output logic              irq_or_out_pin_o,   // Extra pin drive value
  output logic              irq_or_out_pin_oe,  // Extra pin pull-down enable
  input  wire logic         addr_select_pin_0,  // Address select strap 0
  input  wire logic         addr_select_pin_1,  // Address select strap 1
  input  wire logic         addr_select_pin_2,  // Address select strap 2
  output logic              standby             // Idle and no PWM in use
);

  localparam logic [8:0] TICK_LAST = 9'(PWM_TICK_CYC - 1);

  gxp_st_t st;
  gxp_st_t next_st;

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------

  // Pin tie code {bus, high}: ground 00, supply 01, clock 10, data 11
  function automatic logic [1:0] tie_code(input logic dscl, input logic dsda,
                                          input logic s1, input logic s0);
    if (s1 && s0) begin
      tie_code = (dsda && !dscl) ? 2'h2 : 2'h3;
    end else begin
      tie_code = {1'b0, s1};
    end
  endfunction : tie_code

  function automatic logic [6:0] slave_addr(input logic [1:0] c2, input logic [1:0] c1,
                                            input logic [1:0] c0);
    logic [2:0] top;
    case ({c2[1], c1[1]})
      2'h0:    top = 3'h2;
      2'h1:    top = 3'h1;
      2'h3:    top = 3'h5;
      default: top = 3'h6;
    endcase
    slave_addr = {top, c0[1], c2[0], c1[0], c0[0]};
  endfunction : slave_addr

  // Intensity registers below the last hold two ports each, counted from the first intensity offset
  function automatic logic [3:0] pair_lo(input logic [7:0] idx);
    logic [7:0] off;
    off     = 8'(idx - `GXP_REG_INT_BASE);
    pair_lo = {off[2:0], 1'b0};
  endfunction : pair_lo

  function automatic logic [7:0] read_reg(input gxp_st_t s, input logic [7:0] idx);
    read_reg = 8'h00;
    case (idx)
      `GXP_REG_IN_LO:  read_reg = s.pin_s[1][7:0];
      `GXP_REG_IN_HI:  read_reg = s.pin_s[1][15:8];
      `GXP_REG_PH0_LO: read_reg = s.ph0[7:0];
      `GXP_REG_PH0_HI: read_reg = s.ph0[15:8];
      `GXP_REG_PH1_LO: read_reg = s.ph1[7:0];
      `GXP_REG_PH1_HI: read_reg = s.ph1[15:8];
      `GXP_REG_DIR_LO: read_reg = s.dir[7:0];
      `GXP_REG_DIR_HI: read_reg = s.dir[15:8];
      `GXP_REG_MASTER: read_reg = {4'h0, s.master};
      `GXP_REG_CFG:    read_reg = s.cfg;
      `GXP_REG_PWM_LO: read_reg = s.pwm_en[7:0];
      `GXP_REG_PWM_HI: read_reg = s.pwm_en[15:8];
      `GXP_REG_LAST:   read_reg = {4'h0, s.ind[16]};
      default: begin
        if (idx >= `GXP_REG_INT_BASE && idx < `GXP_REG_LAST) begin
          read_reg = {s.ind[pair_lo(idx) | 4'h1], s.ind[pair_lo(idx)]};
        end
      end
    endcase
  endfunction : read_reg

  // Pointer walks the map and wraps after the last register
  function automatic logic [7:0] next_ptr(input logic [7:0] p);
    next_ptr = (p >= `GXP_REG_LAST) ? 8'h00 : 8'(p + 8'h01);
  endfunction : next_ptr

  // ----------------------------------------
  // Edge and condition detection
  // ----------------------------------------
  logic       scl_rise;
  logic       scl_fall;
  logic       start_cond;
  logic       stop_cond;
  logic       bus_quiet;
  logic [6:0] my_addr;
  logic       pwm_used;
  logic [7:0] glob_thr;

  // Only the second synchroniser stage and its delayed copy are looked at
  assign scl_rise   = st.scl_s[1] & ~st.scl_d;
  assign scl_fall   = ~st.scl_s[1] & st.scl_d;
  assign start_cond = st.scl_s[1] & st.scl_d & st.sda_d & ~st.sda_s[1];
  assign stop_cond  = st.scl_s[1] & st.scl_d & ~st.sda_d & st.sda_s[1];
  assign bus_quiet  = (st.scl_s[1] == st.scl_d) && (st.sda_s[1] == st.sda_d);
  assign my_addr    = slave_addr(tie_code(st.dif_scl[2], st.dif_sda[2], st.seen1[2],
                                          st.seen0[2]),
                                 tie_code(st.dif_scl[1], st.dif_sda[1], st.seen1[1],
                                          st.seen0[1]),
                                 tie_code(st.dif_scl[0], st.dif_sda[0], st.seen1[0],
                                          st.seen0[0]));
  assign pwm_used   = (|st.pwm_en) | st.cfg[`GXP_CFG_O16_PWM];
  // Global mode joins master and first intensity into one capped 8-bit level
  assign glob_thr   = ({st.master, st.ind[0]} > `GXP_PWM_STEPS) ? `GXP_PWM_STEPS
                    : {st.master, st.ind[0]};

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    logic [7:0]  rx_byte;
    logic [7:0]  thr;
    logic [16:0] level;
    logic [16:0] pwm_on;
    logic [16:0] pen;
    logic [7:0]  ld_byte;
    rx_byte = 8'h00;
    thr     = 8'h00;
    level   = 17'h00000;
    pwm_on  = 17'h00000;
    pen     = {st.cfg[`GXP_CFG_O16_PWM], st.pwm_en};
    ld_byte = read_reg(st, st.ptr);
    next_st = st;

    // Two-stage synchronisers for all off-domain inputs
    next_st.scl_s = {st.scl_s[0], bus_in.scl};
    next_st.sda_s = {st.sda_s[0], bus_in.sda};
    next_st.scl_d = st.scl_s[1];
    next_st.sda_d = st.sda_s[1];
    next_st.pin_s = {st.pin_s[0], port_pins_i};
    next_st.ad_s  = {st.ad_s[0], {addr_select_pin_2, addr_select_pin_1, addr_select_pin_0}};

    // Learn how each select pin is tied; skip edge cycles to dodge skew
    if (bus_quiet) begin
      next_st.dif_scl = st.dif_scl | (st.ad_s[1] ^ {3{st.scl_s[1]}});
      next_st.dif_sda = st.dif_sda | (st.ad_s[1] ^ {3{st.sda_s[1]}});
      next_st.seen1   = st.seen1 | st.ad_s[1];
      next_st.seen0   = st.seen0 | ~st.ad_s[1];
    end

    // Serial slave
    if (start_cond) begin
      next_st.mode    = GXP_ADDR;
      next_st.bit_cnt = 4'h0;
      next_st.sda_oe  = 1'b0;
    end else if (stop_cond) begin
      next_st.mode    = GXP_IDLE;
      next_st.sda_oe  = 1'b0;
    end else begin
      case (st.mode)
        GXP_ADDR, GXP_WR: begin
          if (scl_rise && st.bit_cnt < 4'h8) begin
            next_st.shreg   = {st.shreg[6:0], st.sda_s[1]};
            next_st.bit_cnt = 4'(st.bit_cnt + 4'h1);
          end else if (scl_fall && st.bit_cnt == 4'h8) begin
            rx_byte = st.shreg;
            if (st.mode == GXP_ADDR) begin
              if (rx_byte[7:1] == my_addr) begin
                next_st.mode      = GXP_ADDR_ACK;
                next_st.sda_oe    = 1'b1;
                next_st.mack      = rx_byte[0];
                next_st.cmd_phase = ~rx_byte[0];
              end else begin
                next_st.mode = GXP_IDLE;
              end
            end else begin
              next_st.mode   = GXP_WR_ACK;
              next_st.sda_oe = 1'b1;
              if (st.cmd_phase) begin
                next_st.ptr       = rx_byte;
                next_st.cmd_phase = 1'b0;
              end else begin
                next_st.ptr = next_ptr(st.ptr);
                case (st.ptr)
                  `GXP_REG_PH0_LO: next_st.ph0[7:0]   = rx_byte;
                  `GXP_REG_PH0_HI: next_st.ph0[15:8]  = rx_byte;
                  `GXP_REG_PH1_LO: next_st.ph1[7:0]   = rx_byte;
                  `GXP_REG_PH1_HI: next_st.ph1[15:8]  = rx_byte;
                  `GXP_REG_DIR_LO: next_st.dir[7:0]   = rx_byte;
                  `GXP_REG_DIR_HI: next_st.dir[15:8]  = rx_byte;
                  `GXP_REG_MASTER: next_st.master     = rx_byte[3:0];
                  `GXP_REG_CFG:    next_st.cfg        = {1'b0, rx_byte[6:0]};
                  `GXP_REG_PWM_LO: next_st.pwm_en[7:0]  = rx_byte;
                  `GXP_REG_PWM_HI: next_st.pwm_en[15:8] = rx_byte;
                  `GXP_REG_LAST:   next_st.ind[16]    = rx_byte[3:0];
                  default: begin
                    if (st.ptr >= `GXP_REG_INT_BASE && st.ptr < `GXP_REG_LAST) begin
                      next_st.ind[pair_lo(st.ptr)]        = rx_byte[3:0];
                      next_st.ind[pair_lo(st.ptr) | 4'h1] = rx_byte[7:4];
                    end
                  end
                endcase
              end
            end
          end
        end
        GXP_ADDR_ACK, GXP_WR_ACK: begin
          if (scl_fall) begin
            next_st.bit_cnt = 4'h0;
            if (st.mode == GXP_ADDR_ACK && st.mack) begin
              // Load first read byte from the stored pointer
              next_st.shreg  = ld_byte;
              next_st.sda_oe = ~ld_byte[7];
              next_st.ptr    = next_ptr(st.ptr);
              next_st.mode   = GXP_RD;
              if (st.ptr == `GXP_REG_IN_LO) next_st.snap[7:0]  = st.pin_s[1][7:0];
              if (st.ptr == `GXP_REG_IN_HI) next_st.snap[15:8] = st.pin_s[1][15:8];
            end else begin
              next_st.sda_oe = 1'b0;
              next_st.mode   = GXP_WR;
            end
          end
        end
        GXP_RD: begin
          if (scl_fall) begin
            if (st.bit_cnt == 4'h7) begin
              next_st.sda_oe = 1'b0;
              next_st.mode   = GXP_RD_ACK;
            end else begin
              next_st.bit_cnt = 4'(st.bit_cnt + 4'h1);
              next_st.shreg   = {st.shreg[6:0], 1'b0};
              next_st.sda_oe  = ~st.shreg[6];
            end
          end
        end
        GXP_RD_ACK: begin
          if (scl_rise) begin
            next_st.mack = ~st.sda_s[1];
          end else if (scl_fall) begin
            if (st.mack) begin
              next_st.bit_cnt = 4'h0;
              next_st.shreg   = ld_byte;
              next_st.sda_oe  = ~ld_byte[7];
              next_st.ptr     = next_ptr(st.ptr);
              next_st.mode    = GXP_RD;
              if (st.ptr == `GXP_REG_IN_LO) next_st.snap[7:0]  = st.pin_s[1][7:0];
              if (st.ptr == `GXP_REG_IN_HI) next_st.snap[15:8] = st.pin_s[1][15:8];
            end else begin
              next_st.mode = GXP_IDLE;
            end
          end
        end
        default: next_st.mode = GXP_IDLE;
      endcase
    end

    // Change detection; a read refreshes the snapshot, which also clears it
    next_st.irq = |((st.pin_s[1] ^ st.snap) & st.dir);

    // PWM tick: held in reset when nothing uses it, which saves power
    if (!pwm_used) begin
      next_st.pwm_div = 9'h000;
      next_st.pwm_cnt = 8'h00;
    end else if (st.pwm_div >= TICK_LAST) begin
      next_st.pwm_div = 9'h000;
      next_st.pwm_cnt = (st.pwm_cnt >= 8'(`GXP_PWM_STEPS - 8'h01)) ? 8'h00
                      : 8'(st.pwm_cnt + 8'h01);
    end else begin
      next_st.pwm_div = 9'(st.pwm_div + 9'h001);
    end

    // Static level per output from the selected blink phase
    if (st.cfg[`GXP_CFG_BLINK_EN] && st.cfg[`GXP_CFG_BLINK_FLIP]) begin
      level = {st.cfg[`GXP_CFG_O16_PH1], st.ph1};
    end else begin
      level = {st.cfg[`GXP_CFG_O16_PH0], st.ph0};
    end

    // Frame of 240 ticks; window m/15, per-output share i/16 of it
    for (int k = 0; k < 17; k++) begin
      thr       = st.cfg[`GXP_CFG_GLOBAL] ? glob_thr
                : 8'(st.master * st.ind[k]);
      pwm_on[k] = st.pwm_cnt < thr;
    end

    // Open-drain: pull low for a low level, only during on-time under PWM
    next_st.drv   = ~st.dir & ~level[15:0] & (~pen[15:0] | pwm_on[15:0]);
    next_st.drv16 = st.cfg[`GXP_CFG_IRQ_MODE] ? st.irq
                  : (~level[16] & (~pen[16] | pwm_on[16]));
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st        <= '0;
      st.scl_s  <= 2'h3;
      st.sda_s  <= 2'h3;
      st.scl_d  <= 1'b1;
      st.sda_d  <= 1'b1;
      st.mode   <= GXP_IDLE;
      st.ph0    <= `GXP_RST_PORT16;
      st.ph1    <= `GXP_RST_PORT16;
      st.dir    <= `GXP_RST_PORT16;
      st.cfg    <= `GXP_RST_CFG;
    end else if (ce) begin
      st <= next_st;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign bus_out.sda_o     = 1'b0;
  assign bus_out.sda_oe    = st.sda_oe;
  assign port_pins_o       = 16'h0000;
  assign port_pins_oe      = st.drv;
  assign irq_or_out_pin_o  = 1'b0;
  assign irq_or_out_pin_oe = st.drv16;
  // Standby whenever no transfer is in progress and the tick is stopped
  assign standby           = (st.mode == GXP_IDLE) && !pwm_used;

endmodule : gxp_expander

// >>> gxp_master_model.sv
// Serial bus master model that frames transfers towards the expander
`timescale 1ns/1ns
module gxp_master_model (
  input  wire logic ref_clk,  // Bench clock, drives on its falling edge
  input  wire logic sda_w,    // Resolved data line level
  output logic      scl,      // Serial clock, stands high outside frames
  output logic      sda       // Data drive, 0 pulls the line low
);
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  // 400 ns, the clock high time of the 900 ns link period
  task automatic half;
    repeat (4) @(negedge ref_clk);
  endtask : half
  // Data falls while clock high
  task automatic start;
    sda = 1'b1;
    half;
    scl = 1'b1;
    half;
    sda = 1'b0;
    half;
    scl = 1'b0;
    @(negedge ref_clk);
  endtask : start
  // Data rises while clock high; line then left to the pull-up
  task automatic stop;
    sda = 1'b0;
    half;
    scl = 1'b1;
    half;
    sda = 1'b1;
    half;
  endtask : stop
  // Data moves one cycle after the clock fall, so no false START or STOP is seen
  task automatic bit_io(input logic b, output logic r);
    sda = b;
    half;
    scl = 1'b1;
    half;
    r = sda_w;
    scl = 1'b0;
    @(negedge ref_clk);
  endtask : bit_io
  task automatic tx(input logic [7:0] v, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(v[i], r);
    end
    bit_io(1'b1, r);
    ack = ~r;
  endtask : tx
  // A high ninth bit ends the read
  task automatic rx(input logic last, output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, v[i]);
    end
    bit_io(last, r);
  endtask : rx
endmodule : gxp_master_model

// >>> gxp_expander_sva.sv
// Pin-level assertions for the port expander
`timescale 1ns/1ns
module gxp_expander_sva
  import gxp_pkg::*;
(
  input wire logic         ref_clk,            // Clock
  input wire logic         resetn,             // Reset, active low
  input wire gxp_bus_in_t  bus_in,             // Serial lines
  input wire gxp_bus_out_t bus_out,            // Data line drive
  input wire logic [15:0]  port_pins_o,        // Port drive value
  input wire logic [15:0]  port_pins_oe,       // Port pull-down enable
  input wire logic         irq_or_out_pin_o,   // Extra pin drive value
  input wire logic         irq_or_out_pin_oe,  // Extra pin pull-down enable
  input wire logic         standby             // Idle indication
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  sequence start_s;
    bus_in.scl && $fell(bus_in.sda);
  endsequence
  sequence stop_s;
    bus_in.scl && $rose(bus_in.sda);
  endsequence
  chk_sda_drain: assert property (bus_out.sda_o == 1'b0)
    else $error("data line driven high");
  chk_port_drain: assert property (port_pins_o == 16'h0000)
    else $error("port driven high");
  chk_extra_drain: assert property (irq_or_out_pin_o == 1'b0)
    else $error("extra pin driven high");
  chk_reset_quiet: assert property ($rose(resetn) |->
      !bus_out.sda_oe && port_pins_oe == 16'h0000 && !irq_or_out_pin_oe && standby)
    else $error("outputs not quiet after reset");
  chk_data_clk_low: assert property ($changed(bus_out.sda_oe) |-> !bus_in.scl)
    else $error("data changed while clock high");
  chk_addr_silent: assert property (start_s |-> !bus_out.sda_oe [*8])
    else $error("driven during address");
  chk_stop_silent: assert property (stop_s |-> !bus_out.sda_oe [*8])
    else $error("driven after stop");
  chk_busy_awake: assert property (bus_out.sda_oe |-> !standby)
    else $error("standby while answering");
  chk_static_idle: assert property (standby && $past(standby) |-> $stable(port_pins_oe))
    else $error("ports moved in standby");
endmodule : gxp_expander_sva

// >>> gxp_expander_bench.sv
// Self-checking bench for the port expander
`timescale 1ns/1ns
module gxp_expander_bench
  import gxp_pkg::*;
;
  typedef struct packed {logic [7:0] cmd; logic [15:0] d; logic [16:0] pin;} gxp_row_t;
  logic         ref_clk;
  logic         resetn;
  logic         m_scl;
  logic         m_sda;
  logic [15:0]  ext;
  logic [15:0]  port_oe;
  logic         irq_oe;
  logic         sby;
  logic [15:0]  v;
  logic         a;
  gxp_bus_out_t bus_out;
  int           err_total;
  int           total_checks;
  int           cyc;
  int           cnt;
  wire logic        sda_w = m_sda & ~bus_out.sda_oe;
  wire logic [15:0] pins  = ext & ~port_oe;
  gxp_row_t rows [6] = '{'{8'h06, 16'h0000, 17'h00000}, '{8'h02, 16'hC35A, 17'h03CA5},
    '{8'h04, 16'hF00F, 17'h03CA5}, '{8'h09, 16'h0021, 17'h13CA5},
    '{8'h09, 16'h0023, 17'h00FF0}, '{8'h09, 16'h0030, 17'h03CA5}};
  gxp_master_model i_mst (.ref_clk(ref_clk), .sda_w(sda_w), .scl(m_scl), .sda(m_sda));
  gxp_expander #(.PWM_TICK_CYC(2)) i_dut (
    .ref_clk(ref_clk), .resetn(resetn), .ce(1'b1), .bus_in({m_scl, sda_w}),
    .bus_out(bus_out), .port_pins_i(pins), .port_pins_o(), .port_pins_oe(port_oe),
    .irq_or_out_pin_o(), .irq_or_out_pin_oe(irq_oe), .addr_select_pin_0(1'b0),
    .addr_select_pin_1(1'b0), .addr_select_pin_2(1'b0), .standby(sby));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string n, input logic [16:0] s, input logic [16:0] e);
    total_checks++;
    if (s !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // All straps grounded give address 0x20
  task automatic wr(input logic [7:0] cmd, input logic [15:0] d, input int n);
    logic [7:0] b [4];
    logic       k;
    b = '{8'h40, cmd, d[7:0], d[15:8]};
    i_mst.start;
    for (int i = 0; i < n + 2; i++) begin
      i_mst.tx(b[i], k);
      chk("ack", {16'h0000, k}, 17'h00001);
    end
    i_mst.stop;
    repeat (10) @(negedge ref_clk);
  endtask : wr
  // Pointer set by a command-only write, then two bytes read
  task automatic rd(input logic [7:0] cmd, output logic [15:0] r);
    logic k;
    wr(cmd, 16'h0000, 0);
    i_mst.start;
    i_mst.tx(8'h41, k);
    chk("read ack", {16'h0000, k}, 17'h00001);
    i_mst.rx(1'b0, r[7:0]);
    i_mst.rx(1'b1, r[15:8]);
    i_mst.stop;
    repeat (10) @(negedge ref_clk);
  endtask : rd
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : print_verdict
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // Cuts a hang short well beyond the expected run length
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_total++;
      print_verdict;
    end
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    ext = 16'hFFFF;
    resetn = 1'b0;
    repeat (20) @(negedge ref_clk);
    resetn = 1'b1;
    @(negedge ref_clk);
    chk("reset drive", {irq_oe, port_oe}, 17'h00000);
    chk("reset standby", {16'h0000, sby}, 17'h00001);
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      wr(rows[i].cmd, rows[i].d, 2);
      chk("pin drive", {irq_oe, port_oe}, rows[i].pin);
    end
    $display("test table done");
    rd(8'h02, v);
    chk("phase0 readback", {1'b0, v}, 17'h0C35A);
    rd(8'h00, v);
    chk("live pins", {1'b0, v}, 17'h0C35A);
    i_mst.start;
    i_mst.tx(8'h42, a);
    i_mst.stop;
    chk("foreign address", {16'h0000, a}, 17'h00000);
    $display("test serial done");
    wr(8'h0C, 16'h0004, 1);
    wr(8'h08, 16'h3008, 2);
    wr(8'h0A, 16'h0001, 1);
    chk("pwm standby", {16'h0000, sby}, 17'h00000);
    cnt = 0;
    repeat (480) begin
      @(negedge ref_clk);
      cnt += port_oe[0];
    end
    chk("pwm on time", 17'(cnt), 17'h00040);
    wr(8'h09, 16'h0034, 1);
    cnt = 0;
    repeat (480) begin
      @(negedge ref_clk);
      cnt += port_oe[0];
    end
    chk("global on time", 17'(cnt), 17'h00108);
    wr(8'h0A, 16'h0000, 1);
    chk("static drive", {sby, port_oe[0]}, 17'h00003);
    $display("test pwm done");
    wr(8'h06, 16'hFFFF, 2);
    wr(8'h09, 16'h0038, 1);
    chk("stale snapshot", {16'h0000, irq_oe}, 17'h00001);
    rd(8'h00, v);
    chk("read clears", {16'h0000, irq_oe}, 17'h00000);
    ext[3] = 1'b0;
    repeat (8) @(negedge ref_clk);
    chk("change flags", {16'h0000, irq_oe}, 17'h00001);
    ext[3] = 1'b1;
    repeat (8) @(negedge ref_clk);
    chk("return clears", {16'h0000, irq_oe}, 17'h00000);
    ext[12] = 1'b0;
    repeat (8) @(negedge ref_clk);
    chk("high byte flags", {16'h0000, irq_oe}, 17'h00001);
    rd(8'h00, v);
    chk("input read", {irq_oe, v}, 17'h0EFFF);
    $display("test interrupt done");
    print_verdict;
  end
endmodule : gxp_expander_bench
bind gxp_expander gxp_expander_sva i_chk (
  .ref_clk(ref_clk), .resetn(resetn), .bus_in(bus_in), .bus_out(bus_out),
  .port_pins_o(port_pins_o), .port_pins_oe(port_pins_oe), .irq_or_out_pin_o(irq_or_out_pin_o),
  .irq_or_out_pin_oe(irq_or_out_pin_oe), .standby(standby));
